// ---- pkg/rsa_pkg.sv ----
// rsa_pkg: constants and carrier types for the reset source aggregator
// assumes a 40 MHz system clock; no other package is needed
package rsa_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ = 40000000; // system clock rate
    localparam int unsigned PWRUP_TIME_MS = 64; // nominal power-up hold
    localparam int unsigned PWRUP_CYCLES = (CLK_HZ / 1000) * PWRUP_TIME_MS;
    localparam int unsigned GLITCH_TIME_NS = 200; // shortest accepted clear pulse
    localparam int unsigned GLITCH_CYCLES =
        ((GLITCH_TIME_NS * (CLK_HZ / 1000000)) + 999) / 1000;
    localparam int unsigned PWRUP_CNT_W = 22; // counter width for the power-up hold
    localparam int unsigned FILT_CNT_W = 8; // counter width for the pin filter

    // ----------------------------------------------------------------
    // field positions of the status word
    // ----------------------------------------------------------------
    localparam int unsigned ST_BROWNOUT = 0;
    localparam int unsigned ST_OPCODE_N = 1;
    localparam int unsigned ST_WD_OVF = 2;
    localparam int unsigned ST_WD_WIN = 3;
    localparam int unsigned ST_STK_UNF = 4;
    localparam int unsigned ST_STK_OVF = 5;
    localparam int unsigned ST_TIMEOUT_N = 6;
    localparam int unsigned ST_PWRDN_N = 7;

    // power-on values of the status word: powerdown, timeout and opcode flags high, rest low
    localparam logic [7:0] STATUS_POR = 8'hc2;

    // configuration bits, sampled from fuses
    typedef struct packed {
        logic extClearEnable; // ext_clear_enable_cfg
        logic lowVoltageProg; // low_voltage_prog_cfg
        logic lowPowerBrownoutEn_n; // erased (1) leaves monitor off
        logic stackFaultResetEnable; // stack_fault_reset_enable
        logic powerupTimerEnable_n; // powerup_timer_enable_n
    } rsa_cfg_t;

    // reset requests from the core and monitors
    typedef struct packed {
        logic mainBrownout; // main brownout request (level)
        logic lowPowerBrownout; // low-power monitor request (level)
        logic watchdogOverflow; // watchdog timer overflow (pulse)
        logic watchdogClearInstr; // clear instruction executed (pulse)
        logic watchdogWindowOpen; // window open (level)
        logic resetOpcode; // reset instruction executed (pulse)
        logic stackOverflow; // call stack overflow (pulse)
        logic stackUnderflow; // call stack underflow (pulse)
        logic progModeExit; // serial programming mode exit (pulse)
        logic selfProgActive; // run-time self programming (level)
    } rsa_req_t;

    // power-control status flags
    typedef struct packed {
        logic powerdownFlag_n; // powerdown_flag (active low)
        logic timeoutFlag_n; // timeout_flag (active low)
        logic stackOverflowFlag; // stack_overflow_flag
        logic stackUnderflowFlag; // stack_underflow_flag
        logic watchdogWindowViolationFlag_n; // watchdog_window_violation_flag
        logic watchdogOverflowFlag_n; // watchdog_overflow_flag
        logic resetOpcodeFlag_n; // reset_opcode_flag_n
        logic brownoutFlag_n; // brownout_reset flag (active low)
    } rsa_status_t;

endpackage : rsa_pkg

// ---- core/rsa_pulse_filter.sv ----
// rsa_pulse_filter: rejects low pulses shorter than a set number of cycles
// assumes the pin is already synchronous to clk_sys
`timescale 1ns/1ps
module rsa_pulse_filter #(
    parameter int unsigned CNT_W = 8,
    parameter int unsigned MIN_CYCLES = 8
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic pinLevel,
    output logic filtLow
);
    // ----------------------------------------------------------------
    // low-time counter
    // ----------------------------------------------------------------
    localparam logic [CNT_W-1:0] LIMIT = CNT_W'(MIN_CYCLES); // accept count

    logic [CNT_W-1:0] lowCount; // cycles the pin has been low
    wire atLimit = (lowCount >= LIMIT); // pulse long enough
    wire [CNT_W-1:0] next_lowCount = pinLevel ? '0 :
        (atLimit ? lowCount : lowCount + CNT_W'(1));

    // count low time; any high sample restarts it
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            lowCount <= '0;
            filtLow <= 1'b0;
        end else begin
            lowCount <= next_lowCount;
            filtLow <= !pinLevel && (next_lowCount >= LIMIT);
        end
    end

    // the output only rises right after a low pin sample
    chk_short_pulse: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $rose(filtLow) |-> $past(!pinLevel))
        else $error("filter passed a pulse after a high sample");
endmodule : rsa_pulse_filter

// ---- core/rsa_reset_aggregator.sv ----
// rsa_reset_aggregator: gathers reset sources into one device reset
// assumes all inputs synchronous to clk_sys, cfg stable, rst_b is power-on reset
`timescale 1ns/1ps
module rsa_reset_aggregator
    import rsa_pkg::*;
#(
    parameter int unsigned PWRUP_HOLD = rsa_pkg::PWRUP_CYCLES,
    parameter int unsigned FILTER_CYCLES = rsa_pkg::GLITCH_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire rsa_pkg::rsa_cfg_t cfg,
    input wire rsa_pkg::rsa_req_t req,
    input wire logic clearPinIn,
    input wire logic swPullupEn,
    output logic deviceReset,
    output logic clearPinOut,
    output logic clearPinOe,
    output logic clearPinPullup,
    output logic gpioIn,
    output logic brownoutReset,
    output rsa_pkg::rsa_status_t status,
    input wire logic statusWrite,
    input wire rsa_pkg::rsa_status_t statusWdata
);
    import rsa_pkg::*;

    // ----------------------------------------------------------------
    // pin configuration and filter
    // ----------------------------------------------------------------
    wire clearEnabled = cfg.extClearEnable | cfg.lowVoltageProg;
    logic clearLowFilt; // filtered low level of the pin

    // pin noise filter
    rsa_pulse_filter #(
        .CNT_W(FILT_CNT_W),
        .MIN_CYCLES(FILTER_CYCLES)
    ) u_filter (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .pinLevel(clearPinIn),
        .filtLow(clearLowFilt)
    );

    // ----------------------------------------------------------------
    // request decode
    // ----------------------------------------------------------------
    wire clearReq = clearEnabled & clearLowFilt;
    wire lpbEnabled = !cfg.lowPowerBrownoutEn_n;
    wire brownReq = req.mainBrownout | (lpbEnabled & req.lowPowerBrownout);
    wire wdOvfEvt = req.watchdogOverflow;
    wire wdWinEvt = req.watchdogClearInstr & !req.watchdogWindowOpen;
    wire stkOvfEvt = cfg.stackFaultResetEnable & req.stackOverflow;
    wire stkUnfEvt = cfg.stackFaultResetEnable & req.stackUnderflow;
    wire opcodeEvt = req.resetOpcode;
    wire progExitEvt = req.progModeExit;
    // self programming is deliberately not a request term
    wire pulseEvt = wdOvfEvt | wdWinEvt | stkOvfEvt | stkUnfEvt | opcodeEvt;
    wire levelReq = clearReq | brownReq;

    // ----------------------------------------------------------------
    // power-up timer
    // ----------------------------------------------------------------
    localparam logic [PWRUP_CNT_W-1:0] HOLD_LAST = PWRUP_CNT_W'(PWRUP_HOLD - 1);
    logic [PWRUP_CNT_W-1:0] pwrupCount; // cycles left in hold
    logic pwrupBusy; // hold in progress
    logic brownSeen; // brownout was active last cycle
    logic progExitSeen; // programming exit acts as power-on
    wire pwrupStart = (brownSeen & !brownReq) | progExitSeen;
    wire pwrupArm = !cfg.powerupTimerEnable_n;
    wire pwrupDone = (pwrupCount == '0);

    // run the power-up hold after brownout or programming exit release
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            pwrupCount <= '0;
            pwrupBusy <= 1'b0;
            brownSeen <= 1'b1;
            progExitSeen <= 1'b0;
        end else begin
            brownSeen <= brownReq;
            progExitSeen <= progExitEvt;
            if (pwrupStart && pwrupArm) begin
                pwrupCount <= HOLD_LAST;
                pwrupBusy <= 1'b1;
            end else if (pwrupBusy && !pwrupDone) begin
                pwrupCount <= pwrupCount - PWRUP_CNT_W'(1);
            end else begin
                pwrupBusy <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // pulse-event stretch: hold reset one cycle after a pulse source
    // ----------------------------------------------------------------
    logic pulseHeld; // pulse request seen last cycle
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            pulseHeld <= 1'b0;
        end else begin
            pulseHeld <= pulseEvt | progExitEvt;
        end
    end

    // ----------------------------------------------------------------
    // common device reset
    // ----------------------------------------------------------------
    // the start term bridges the cycle before the hold counter is loaded
    wire anyReq = levelReq | pulseEvt | progExitEvt | pulseHeld | progExitSeen | pwrupBusy
        | (pwrupStart & pwrupArm);
    wire next_deviceReset = anyReq;

    // registered so release aligns to clk_sys
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            deviceReset <= 1'b1;
            brownoutReset <= 1'b1;
        end else begin
            deviceReset <= next_deviceReset;
            brownoutReset <= brownReq;
        end
    end

    // ----------------------------------------------------------------
    // pin drive: never driven, pull-up by mode
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            clearPinOut <= 1'b0;
            clearPinOe <= 1'b0;
            clearPinPullup <= 1'b1;
            gpioIn <= 1'b0;
        end else begin
            clearPinOut <= 1'b0;
            clearPinOe <= 1'b0;
            clearPinPullup <= clearEnabled ? 1'b1 : swPullupEn;
            gpioIn <= clearEnabled ? 1'b0 : clearPinIn;
        end
    end

    // ----------------------------------------------------------------
    // status flags: hardware set wins over software write
    // ----------------------------------------------------------------
    rsa_status_t next_status; // next status value
    rsa_status_t wrBase; // after software write
    always_comb begin
        wrBase = statusWrite ? statusWdata : status;
        next_status = wrBase;
        if (brownReq) begin
            next_status.brownoutFlag_n = 1'b0;
        end
        if (wdOvfEvt) begin
            next_status.watchdogOverflowFlag_n = 1'b0;
            next_status.timeoutFlag_n = 1'b0;
            next_status.powerdownFlag_n = 1'b1;
        end
        if (wdWinEvt) begin
            next_status.watchdogWindowViolationFlag_n = 1'b0;
        end
        if (opcodeEvt) begin
            next_status.resetOpcodeFlag_n = 1'b0;
        end
        if (stkOvfEvt) begin
            next_status.stackOverflowFlag = 1'b1;
        end
        if (stkUnfEvt) begin
            next_status.stackUnderflowFlag = 1'b1;
        end
        if (progExitEvt) begin
            next_status = rsa_status_t'(STATUS_POR);
        end
    end

    // status register
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            status <= rsa_status_t'(STATUS_POR);
        end else begin
            status <= next_status;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_pinLow;
        clearLowFilt && clearEnabled;
    endsequence

    chk_clear_off: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (!cfg.extClearEnable && !cfg.lowVoltageProg) |=> !clearPinPullup || swPullupEn)
        else $error("disabled clear pin kept forced pull-up");
    chk_pin_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
        s_pinLow |=> deviceReset)
        else $error("clear pin low did not hold reset");
    chk_pin_input: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !clearPinOe && !clearPinOut)
        else $error("clear pin was driven");
    chk_pullup_on: assert property (@(posedge clk_sys) disable iff (!rst_b)
        clearEnabled |=> clearPinPullup)
        else $error("pull-up missing on enabled clear pin");
    chk_lpb_gate: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (cfg.lowPowerBrownoutEn_n && !req.mainBrownout) |=> !brownoutReset)
        else $error("disabled low-power monitor caused brownout");
    chk_brown_or: assert property (@(posedge clk_sys) disable iff (!rst_b)
        brownReq |=> brownoutReset && deviceReset && !status.brownoutFlag_n)
        else $error("brownout not merged into reset and flag");
    chk_wd_window: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (req.watchdogClearInstr && !req.watchdogWindowOpen) |=>
        (deviceReset && !status.watchdogWindowViolationFlag_n))
        else $error("window violation missed");
    chk_wd_ovf: assert property (@(posedge clk_sys) disable iff (!rst_b)
        wdOvfEvt |=> (!status.timeoutFlag_n && !status.watchdogOverflowFlag_n)[*1]
        ##1 deviceReset)
        else $error("watchdog overflow flags or reset missing");
    chk_opcode: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (opcodeEvt && !progExitEvt) |=> !status.resetOpcodeFlag_n && deviceReset)
        else $error("reset opcode not recorded");
    chk_stack_gate: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (!cfg.stackFaultResetEnable && req.stackOverflow && !statusWrite
        && !status.stackOverflowFlag && !progExitEvt) |=> !status.stackOverflowFlag)
        else $error("stack fault flagged while disabled");
    chk_prog_exit: assert property (@(posedge clk_sys) disable iff (!rst_b)
        progExitEvt |=> (status == rsa_status_t'(STATUS_POR)) ##1 deviceReset)
        else $error("programming exit not like power-on");
    chk_selfprog: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (req.selfProgActive && !anyReq) |=> !deviceReset)
        else $error("self programming caused reset");
    chk_pwrup_start: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (pwrupStart && pwrupArm) |=> pwrupBusy && (pwrupCount == HOLD_LAST))
        else $error("power-up hold not started");
    chk_release: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $fell(deviceReset) |-> $past(!anyReq))
        else $error("reset released with request active");
endmodule : rsa_reset_aggregator

// ---- verification/rsa_src_model.sv ----
// rsa_src_model: far side of the aggregator: clear pin, monitors, watchdog, core
// assumes the bench calls its tasks; all changes land on the falling clock edge
`timescale 1ns/1ps
module rsa_src_model
    import rsa_pkg::*;
(
    input wire logic clk_sys,
    input wire logic clearPinOut,
    input wire logic clearPinOe,
    input wire logic clearPinPullup,
    output rsa_pkg::rsa_req_t req,
    output logic clearPinIn
);
    // ----------------------------------------------------------------
    // pin and request state
    // ----------------------------------------------------------------
    logic pinLow = 1'b0; // outside switch pulls the pin low
    logic floatV = 1'b0; // undriven, unpulled pin wanders
    initial req = '0;
    // floating level changes every cycle
    always @(negedge clk_sys) floatV <= ~floatV;
    // wired pin level from every party that can drive it
    assign clearPinIn = clearPinOe ? clearPinOut : pinLow ? 1'b0 :
        clearPinPullup ? 1'b1 : floatV;
    // one-cycle event from core or watchdog
    task automatic fire(input rsa_req_t m);
        @(negedge clk_sys) req = req | m;
        @(negedge clk_sys) req = req & ~m;
    endtask : fire
    // level request raised or dropped
    task automatic hold(input rsa_req_t m, input logic on);
        @(negedge clk_sys) req = on ? (req | m) : (req & ~m);
    endtask : hold
endmodule : rsa_src_model

// ---- verification/tb_top.sv ----
// tb_top: self-checking bench for the reset source aggregator
// assumes rsa_src_model plays the far side; power-up hold shortened to 16
`timescale 1ns/1ps
module tb_top;
    import rsa_pkg::*;
    // ----------------------------------------------------------------
    // request masks, one per source
    // ----------------------------------------------------------------
    localparam int unsigned HOLD = 16; // shortened power-up hold
    localparam rsa_req_t M_MBO = 10'h200; // main brownout
    localparam rsa_req_t M_LPB = 10'h100; // low-power brownout
    localparam rsa_req_t M_WOV = 10'h080; // watchdog overflow
    localparam rsa_req_t M_CLR = 10'h040; // watchdog clear
    localparam rsa_req_t M_WIN = 10'h020; // window open
    localparam rsa_req_t M_OPC = 10'h010; // reset opcode
    localparam rsa_req_t M_OVF = 10'h008; // stack overflow
    localparam rsa_req_t M_UNF = 10'h004; // stack underflow
    localparam rsa_req_t M_PEX = 10'h002; // programming exit
    localparam rsa_req_t M_SPA = 10'h001; // self programming
    logic clk_sys = 1'b0; // system clock
    logic rst_b = 1'b0; // power-on reset
    rsa_cfg_t cfg = 5'b10101; // clear on, lp monitor off, timer off
    logic swPullupEn = 1'b0; // software pull-up
    logic statusWrite = 1'b0; // status write strobe
    rsa_status_t statusWdata = 8'h00; // status write data
    rsa_req_t req; // requests from model
    logic clearPinIn, deviceReset, clearPinOut, clearPinOe, clearPinPullup;
    logic gpioIn, brownoutReset;
    rsa_status_t status; // status flags
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    int n;
    always #12.5 clk_sys = ~clk_sys;
    rsa_reset_aggregator #(.PWRUP_HOLD(HOLD)) i_rsa_reset_aggregator (.clk_sys(clk_sys),
        .rst_b(rst_b), .cfg(cfg), .req(req), .clearPinIn(clearPinIn), .swPullupEn(swPullupEn),
        .deviceReset(deviceReset), .clearPinOut(clearPinOut), .clearPinOe(clearPinOe),
        .clearPinPullup(clearPinPullup), .gpioIn(gpioIn), .brownoutReset(brownoutReset),
        .status(status), .statusWrite(statusWrite), .statusWdata(statusWdata));
    rsa_src_model i_rsa_src_model (.clk_sys(clk_sys), .clearPinOut(clearPinOut),
        .clearPinOe(clearPinOe), .clearPinPullup(clearPinPullup), .req(req),
        .clearPinIn(clearPinIn));
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    // compare and count
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // watch 30 cycles for any device reset
    task automatic expect_rst(input logic exp);
        logic seen;
        seen = deviceReset;
        repeat (30) @(negedge clk_sys) seen = seen | deviceReset;
        chk({7'h0, seen}, {7'h0, exp});
    endtask : expect_rst
    // drop every request, wait for release
    task automatic settle(input string name);
        int k;
        k = 0;
        @(negedge clk_sys);
        i_rsa_src_model.req = '0;
        i_rsa_src_model.pinLow = 1'b0;
        while (deviceReset !== 1'b0 && k < 200) begin
            @(negedge clk_sys);
            k++;
        end
        chk({7'h0, deviceReset}, 8'h00);
        $display("test %s done", name);
    endtask : settle
    // software write of the status flags
    task automatic wr(input logic [7:0] d);
        @(negedge clk_sys);
        statusWrite = 1'b1;
        statusWdata = d;
        @(negedge clk_sys);
        statusWrite = 1'b0;
    endtask : wr
    // verdict and end of run
    task automatic stop_test;
        $display("comparisons=%0d mismatches=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test
    // hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            stop_test();
        end
    end
    // ----------------------------------------------------------------
    // test sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (10) @(negedge clk_sys);
        chk(status, STATUS_POR);
        chk({clearPinOe, clearPinOut, clearPinPullup, deviceReset}, 8'h03);
        rst_b = 1'b1;
        settle("reset");
        // raise every active-low flag so later clears can be seen
        wr(8'hcf);
        i_rsa_src_model.fire(M_OPC);
        expect_rst(1'b1);
        chk({7'h0, status[ST_OPCODE_N]}, 8'h00);
        settle("opcode");
        // stack faults refused, then honoured
        for (int en = 0; en < 2; en++) begin
            cfg.stackFaultResetEnable = en[0];
            i_rsa_src_model.fire(M_OVF);
            expect_rst(en[0]);
            chk({7'h0, status[ST_STK_OVF]}, {7'h0, en[0]});
            settle("stack overflow");
            i_rsa_src_model.fire(M_UNF);
            expect_rst(en[0]);
            chk({7'h0, status[ST_STK_UNF]}, {7'h0, en[0]});
            settle("stack underflow");
        end
        i_rsa_src_model.hold(M_WIN, 1'b1);
        i_rsa_src_model.fire(M_CLR);
        expect_rst(1'b0);
        i_rsa_src_model.hold(M_WIN, 1'b0);
        i_rsa_src_model.fire(M_CLR);
        expect_rst(1'b1);
        chk({7'h0, status[ST_WD_WIN]}, 8'h00);
        settle("window");
        i_rsa_src_model.fire(M_WOV);
        expect_rst(1'b1);
        chk({status[ST_PWRDN_N], status[ST_TIMEOUT_N], status[ST_WD_OVF]}, 8'h04);
        settle("overflow");
        i_rsa_src_model.hold(M_LPB, 1'b1);
        expect_rst(1'b0);
        chk({7'h0, brownoutReset}, 8'h00);
        cfg.lowPowerBrownoutEn_n = 1'b0;
        expect_rst(1'b1);
        chk({brownoutReset, status[ST_BROWNOUT]}, 8'h02);
        settle("low power brownout");
        wr(8'hff);
        i_rsa_src_model.hold(M_MBO, 1'b1);
        expect_rst(1'b1);
        chk({brownoutReset, status[ST_BROWNOUT]}, 8'h02);
        settle("main brownout");
        // every clear-pin configuration, pin held low
        for (int k = 0; k < 4; k++) begin
            {cfg.extClearEnable, cfg.lowVoltageProg} = k[1:0];
            i_rsa_src_model.pinLow = 1'b1;
            expect_rst(k != 0);
            chk({clearPinOe, clearPinOut, clearPinPullup, gpioIn}, {6'h0, k != 0, 1'b0});
            settle("clear pin");
        end
        cfg.extClearEnable = 1'b0;
        cfg.lowVoltageProg = 1'b0;
        swPullupEn = 1'b1;
        repeat (4) @(negedge clk_sys);
        chk({clearPinOe, clearPinOut, clearPinPullup, gpioIn}, 8'h03);
        cfg.extClearEnable = 1'b1;
        i_rsa_src_model.pinLow = 1'b1;
        repeat (3) @(negedge clk_sys);
        i_rsa_src_model.pinLow = 1'b0;
        expect_rst(1'b0);
        settle("glitch");
        i_rsa_src_model.hold(M_SPA, 1'b1);
        expect_rst(1'b0);
        settle("self programming");
        i_rsa_src_model.fire(M_PEX);
        expect_rst(1'b1);
        chk(status, STATUS_POR);
        settle("programming exit");
        cfg.powerupTimerEnable_n = 1'b0;
        i_rsa_src_model.hold(M_MBO, 1'b1);
        repeat (3) @(negedge clk_sys);
        i_rsa_src_model.hold(M_MBO, 1'b0);
        n = 0;
        while (deviceReset === 1'b1 && n < 200) begin
            @(negedge clk_sys);
            n++;
        end
        chk({7'h0, n >= HOLD}, 8'h01);
        settle("power-up timer");
        stop_test();
    end
endmodule : tb_top
